//--- rsr_pkg.sv
/*
 * Constants and types for the run-start and ramp controller: timebase,
 * register offsets, field positions, reset values and the state encoding.
 * Assumes a single 200 MHz system clock.
 */
package rsr_pkg;

  // timebase
  localparam int CLK_PERIOD_NS  = 5;
  localparam int TICK_PERIOD_NS = 10_000_000;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_ACCEL_TIME  = 8'h04;
  localparam logic [7:0] OFS_DECEL_TIME  = 8'h08;
  localparam logic [7:0] OFS_MAX_FREQ    = 8'h0c;
  localparam logic [7:0] OFS_TARGET_FREQ = 8'h10;
  localparam logic [7:0] OFS_RETRY_COUNT = 8'h14;
  localparam logic [7:0] OFS_RETRY_DELAY = 8'h18;
  localparam logic [7:0] OFS_STATUS      = 8'h1c;
  localparam logic [7:0] OFS_OUT_FREQ    = 8'h20;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h24;
  localparam logic [7:0] OFS_INT_MASK    = 8'h28;

  // control register fields
  localparam int CTRL_SRC_LSB    = 0;
  localparam int CTRL_PWRON      = 3;
  localparam int CTRL_RSTRT      = 4;
  localparam int CTRL_RAMP_REF   = 5;
  localparam int CTRL_TSCALE_LSB = 6;
  localparam int CTRL_SW_RUN     = 8;
  localparam int CTRL_SSOPT_LSB  = 16;
  localparam int SS_PWRON_BIT    = 4;
  localparam int SS_TRIP_BIT     = 2;

  // command sources
  localparam logic [2:0] SRC_RESET        = 3'h1;
  localparam logic [2:0] SRC_TERM_ONE     = 3'h1;
  localparam logic [2:0] SRC_TERM_TWO     = 3'h2;

  // time scale codes and ticks of 10 ms per unit
  localparam logic [1:0]  TS_10MS     = 2'h0;
  localparam logic [1:0]  TS_100MS    = 2'h1;
  localparam logic [1:0]  TS_1S       = 2'h2;
  localparam logic [23:0] TS_MUL_100MS = 24'h00000a;
  localparam logic [23:0] TS_MUL_1S    = 24'h000064;

  // reset values and limits
  localparam logic [15:0] ACCEL_RST   = 16'h00c8;
  localparam logic [15:0] DECEL_RST   = 16'h012c;
  localparam logic [15:0] TIME_MIN    = 16'h0000;
  localparam logic [15:0] TIME_MAX    = 16'h1770;
  localparam logic [15:0] MAXF_RST    = 16'h1770;
  localparam logic [15:0] MAXF_MIN    = 16'h0fa0;
  localparam logic [15:0] MAXF_MAX    = 16'h9c40;
  localparam logic [15:0] RETRY_N_MAX = 16'h000a;
  localparam logic [15:0] RETRY_D_RST = 16'h000a;
  localparam logic [15:0] RETRY_D_MAX = 16'h0258;
  localparam logic [13:0] DLY_TICKS_PER_UNIT = 14'h000a;

  // interrupt bits
  localparam int IRQ_TRIP    = 0;
  localparam int IRQ_START   = 1;
  localparam int IRQ_EXHAUST = 2;
  localparam int IRQ_REACHED = 3;
  localparam int IRQ_W       = 4;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_HOLD_OFF = 5'h02,
    ST_RUN      = 5'h04,
    ST_TRIP     = 5'h08,
    ST_RETRY    = 5'h10
  } rsr_state_type;

endpackage : rsr_pkg

//--- rsr_run_ramp_ctrl.sv
/*
 * Run-start gating, trip restart and ramp generator of a motor drive,
 * with an APB register slave and a masked level interrupt.
 * Assumes terminal, trip and reset inputs synchronous to SYS_CLK, and an
 * output stage that honours OUTPUT_EN and follows OUT_FREQ (0.01 Hz units).
 */
//
// Overview of operation
// RULE1: terminal mode plus power-on run starts at power-up
// RULE2: otherwise power-up run waits for off then on
// RULE3: option bit4 requests speed search on power-up start
// RULE4: without search start from zero and accelerate
// RULE5: trip disables output at once, motor coasts
// RULE6: reset-restart resumes from active terminal command
// RULE7: retry count 0..10 and delay 0..60 s
// RULE8: option bit2 requests speed search after trip restart
// RULE9: no reset-restart needs reset then off then on
// RULE10: reference 0 scales ramps to maximum frequency
// RULE11: reference 1 scales ramps to frequency change
// RULE12: accel 20.0 and decel 30.0, range 0..600.0
// RULE13: slope fixed against maximum frequency 40..400 Hz
// RULE14: time unit code selects 0.01, 0.1, 1 s
// RULE15: unit change keeps count, rescales time
// RULE16: count auto restarts, stop when used up
`timescale 1ns/1ps
module rsr_run_ramp_ctrl
  import rsr_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // terminal block and fault inputs
  input  wire logic        RUN_CMD,
  input  wire logic        FAULT_TRIP,
  input  wire logic        FAULT_RESET,
  input  wire logic [15:0] SEARCH_FREQ,
  // output stage
  output logic             OUTPUT_EN,
  output logic             SEARCH_REQ,
  output logic      [15:0] OUT_FREQ,
  output logic             IRQ
);

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  function automatic logic [23:0] ramp_ticks(input logic [15:0] t, input logic [1:0] ts);
    logic [23:0] w;
    w = {8'h00, t};
    unique case (ts)
      TS_10MS:  ramp_ticks = w;
      TS_100MS: ramp_ticks = w * TS_MUL_100MS;
      default:  ramp_ticks = w * TS_MUL_1S;
    endcase
  endfunction : ramp_ticks

  //////////////////////////////////////////////////////////////////////////
  // registers

  logic [2:0]        src_q;
  logic              pwron_q, rstrt_q, rref_q, swrun_q;
  logic [1:0]        ts_q;
  logic [7:0]        ssopt_q;
  logic [15:0]       accel_q, decel_q, maxf_q, target_q, retry_n_q, retry_d_q;
  logic [IRQ_W-1:0]  int_stat_q, int_mask_q, int_set;
  logic [31:0]       prdata_q;
  logic              wr_en, setup, mapped;
  logic [31:0]       rd_val;
  rsr_state_type     st_q;
  logic [3:0]        retries_q;
  logic              fresh_q;
  logic [15:0]       freq_q;

  assign setup  = PSEL & ~PENABLE;
  assign wr_en  = PSEL & PENABLE & PWRITE & mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = prdata_q;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (PADDR)
      OFS_CTRL:        rd_val = {8'h00, ssopt_q, 7'h00, swrun_q, ts_q, rref_q, rstrt_q,
                                 pwron_q, src_q};
      OFS_ACCEL_TIME:  rd_val = {16'h0000, accel_q};
      OFS_DECEL_TIME:  rd_val = {16'h0000, decel_q};
      OFS_MAX_FREQ:    rd_val = {16'h0000, maxf_q};
      OFS_TARGET_FREQ: rd_val = {16'h0000, target_q};
      OFS_RETRY_COUNT: rd_val = {16'h0000, retry_n_q};
      OFS_RETRY_DELAY: rd_val = {16'h0000, retry_d_q};
      OFS_STATUS:      rd_val = {19'h00000, st_q, retries_q, 2'h0, fresh_q, OUTPUT_EN};
      OFS_OUT_FREQ:    rd_val = {16'h0000, freq_q};
      OFS_INT_STATUS:  rd_val = {28'h0000000, int_stat_q};
      OFS_INT_MASK:    rd_val = {28'h0000000, int_mask_q};
      default:         mapped = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_val;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      src_q     <= SRC_RESET;
      pwron_q   <= 1'b0;
      rstrt_q   <= 1'b0;
      rref_q    <= 1'b0;
      ts_q      <= TS_100MS;
      swrun_q   <= 1'b0;
      ssopt_q   <= 8'h00;
      accel_q   <= ACCEL_RST;
      decel_q   <= DECEL_RST;
      maxf_q    <= MAXF_RST;
      target_q  <= 16'h0000;
      retry_n_q <= 16'h0000;
      retry_d_q <= RETRY_D_RST;
    end else if (wr_en) begin
      unique case (PADDR)
        OFS_CTRL: begin
          src_q   <= PWDATA[CTRL_SRC_LSB +: 3];
          pwron_q <= PWDATA[CTRL_PWRON];
          rstrt_q <= PWDATA[CTRL_RSTRT];
          rref_q  <= PWDATA[CTRL_RAMP_REF];
          swrun_q <= PWDATA[CTRL_SW_RUN];
          ssopt_q <= PWDATA[CTRL_SSOPT_LSB +: 8];
          // RULE14 unit code, unused code 3 ignored
          if (PWDATA[CTRL_TSCALE_LSB +: 2] != 2'h3) begin
            ts_q <= PWDATA[CTRL_TSCALE_LSB +: 2];
          end
        end
        // RULE12 ramp times clamped to range
        OFS_ACCEL_TIME:  accel_q   <= clamp16(PWDATA[15:0], TIME_MIN, TIME_MAX);
        OFS_DECEL_TIME:  decel_q   <= clamp16(PWDATA[15:0], TIME_MIN, TIME_MAX);
        // RULE13 maximum frequency range
        OFS_MAX_FREQ:    maxf_q    <= clamp16(PWDATA[15:0], MAXF_MIN, MAXF_MAX);
        OFS_TARGET_FREQ: target_q  <= PWDATA[15:0];
        // RULE7 retry count and delay ranges
        OFS_RETRY_COUNT: retry_n_q <= clamp16(PWDATA[15:0], TIME_MIN, RETRY_N_MAX);
        OFS_RETRY_DELAY: retry_d_q <= clamp16(PWDATA[15:0], TIME_MIN, RETRY_D_MAX);
        default: ;
      endcase
    end
  end

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      int_stat_q <= 4'h0;
      int_mask_q <= 4'h0;
    end else begin
      if (wr_en && PADDR == OFS_INT_STATUS) begin
        int_stat_q <= int_set | (int_stat_q & ~PWDATA[IRQ_W-1:0]);
      end else begin
        int_stat_q <= int_set | int_stat_q;
      end
      if (wr_en && PADDR == OFS_INT_MASK) begin
        int_mask_q <= PWDATA[IRQ_W-1:0];
      end
    end
  end

  assign IRQ = |(int_stat_q & int_mask_q);

  //////////////////////////////////////////////////////////////////////////
  // timebase and run control

  logic [21:0] tick_cnt_q;
  logic        tick_en;
  logic [13:0] dly_q;
  logic        term, run_src, start_go, start_search, search_q, blocked;
  logic        trip_rst_ok;
  rsr_state_type st_d;

  assign tick_en = (tick_cnt_q == 22'(TICK_CYCLES_P - 1));

  always_ff @(posedge SYS_CLK) begin
    if (RST || tick_en) begin
      tick_cnt_q <= 22'h000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 22'h000001;
    end
  end

  assign term    = (src_q == SRC_TERM_ONE) || (src_q == SRC_TERM_TWO);
  assign run_src = term ? RUN_CMD : swrun_q;
  // RULE2 command already on since power-up is ignored
  assign blocked = term & fresh_q & ~pwron_q;
  assign trip_rst_ok = (st_q == ST_TRIP) & ~FAULT_TRIP & FAULT_RESET & (retries_q == 4'h0);

  always_comb begin
    st_d         = st_q;
    start_go     = 1'b0;
    start_search = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (run_src && blocked) begin
          st_d = ST_HOLD_OFF;
        end else if (run_src) begin
          // RULE1 power-up start from active terminal command
          st_d         = ST_RUN;
          start_go     = 1'b1;
          // RULE3 search on power-up start
          start_search = term & fresh_q & ssopt_q[SS_PWRON_BIT];
        end
      end
      ST_HOLD_OFF: begin
        if (!run_src) begin
          st_d = ST_IDLE;
        end
      end
      ST_RUN: begin
        if (!run_src && freq_q == 16'h0000) begin
          st_d = ST_IDLE;
        end
      end
      ST_TRIP: begin
        // RULE16 auto restart only while count remains
        if (!FAULT_TRIP && retries_q != 4'h0) begin
          st_d = ST_RETRY;
        end else if (trip_rst_ok && rstrt_q && term && run_src) begin
          // RULE6 resume after trip reset
          st_d         = ST_RUN;
          start_go     = 1'b1;
          // RULE8 search after trip restart
          start_search = ssopt_q[SS_TRIP_BIT];
        end else if (trip_rst_ok) begin
          // RULE9 needs off then on again
          st_d = run_src ? ST_HOLD_OFF : ST_IDLE;
        end
      end
      ST_RETRY: begin
        if (dly_q == 14'h0000) begin
          st_d         = run_src ? ST_RUN : ST_IDLE;
          start_go     = run_src;
          start_search = run_src & ssopt_q[SS_TRIP_BIT];
        end
      end
    endcase
    // RULE5 trip overrides every state
    if (FAULT_TRIP) begin
      st_d         = ST_TRIP;
      start_go     = 1'b0;
      start_search = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // power-up marker follows the terminal input itself, so a source
  // change while the command is held keeps the power-up case alive
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      fresh_q <= 1'b1;
    end else if (!RUN_CMD || start_go) begin
      fresh_q <= 1'b0;
    end
  end

  // RULE16 reload on a fresh start, spend one per auto restart
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      retries_q <= 4'h0;
    end else if (start_go && st_q == ST_IDLE) begin
      retries_q <= retry_n_q[3:0];
    end else if (st_q == ST_RETRY && st_d != ST_RETRY && st_d != ST_TRIP) begin
      retries_q <= retries_q - 4'h1;
    end
  end

  // RULE7 restart delay counted in 10 ms ticks
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      dly_q <= 14'h0000;
    end else if (st_q == ST_TRIP) begin
      dly_q <= 14'(retry_d_q[9:0] * DLY_TICKS_PER_UNIT);
    end else if (tick_en && dly_q != 14'h0000) begin
      dly_q <= dly_q - 14'h0001;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      search_q <= 1'b0;
    end else begin
      search_q <= start_go & start_search;
    end
  end

  // RULE5 output gated combinationally so the trip cuts it in-cycle
  assign OUTPUT_EN  = (st_q == ST_RUN) & ~FAULT_TRIP;
  assign SEARCH_REQ = search_q;

  //////////////////////////////////////////////////////////////////////////
  // ramp generator: one 0.01 Hz step per clock while the accumulator
  // holds a full period; at most span steps per tick, far below the
  // clock count of a tick

  logic [15:0] tgt_eff, tgt_prev_q, seg_span_q, span, diff, search_f;
  logic [23:0] acc_q, den;
  logic        up, moving, at_tgt_q;

  assign tgt_eff  = (st_q == ST_RUN && run_src) ? ((target_q > maxf_q) ? maxf_q : target_q)
                                                 : 16'h0000;
  assign up       = tgt_eff > freq_q;
  assign moving   = tgt_eff != freq_q;
  assign diff     = up ? tgt_eff - freq_q : freq_q - tgt_eff;
  assign search_f = (SEARCH_FREQ > maxf_q) ? maxf_q : SEARCH_FREQ;
  // RULE10 RULE13 span is the maximum frequency, else RULE11 the change
  assign span     = rref_q ? seg_span_q : maxf_q;
  // RULE15 stored count reinterpreted live in the current unit
  assign den      = up ? ramp_ticks(accel_q, ts_q) : ramp_ticks(decel_q, ts_q);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      freq_q     <= 16'h0000;
      acc_q      <= 24'h000000;
      tgt_prev_q <= 16'h0000;
      seg_span_q <= 16'h0000;
    end else if (FAULT_TRIP || st_q == ST_TRIP) begin
      freq_q <= 16'h0000;
      acc_q  <= 24'h000000;
    end else if (start_go) begin
      // RULE4 standstill start unless a search was requested
      freq_q     <= start_search ? search_f : 16'h0000;
      acc_q      <= 24'h000000;
      tgt_prev_q <= 16'h0000;
    end else if (tgt_eff != tgt_prev_q) begin
      // RULE11 segment span latched at each new target
      tgt_prev_q <= tgt_eff;
      seg_span_q <= diff;
      acc_q      <= 24'h000000;
    end else if (!moving) begin
      acc_q <= 24'h000000;
    end else if (den == 24'h000000) begin
      freq_q <= tgt_eff;
    end else if (tick_en) begin
      acc_q <= acc_q + {8'h00, span};
    end else if (acc_q >= den) begin
      freq_q <= up ? freq_q + 16'h0001 : freq_q - 16'h0001;
      acc_q  <= acc_q - den;
    end
  end

  assign OUT_FREQ = freq_q;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      at_tgt_q <= 1'b1;
    end else begin
      at_tgt_q <= ~moving;
    end
  end

  assign int_set[IRQ_TRIP]    = FAULT_TRIP & (st_q != ST_TRIP);
  assign int_set[IRQ_START]   = start_go;
  assign int_set[IRQ_EXHAUST] = FAULT_TRIP & (st_q != ST_TRIP) & (retry_n_q != 16'h0000)
                                & (retries_q == 4'h0);
  assign int_set[IRQ_REACHED] = (st_q == ST_RUN) & ~moving & ~at_tgt_q & (tgt_eff != 16'h0000);

  //////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_pwron_cmd;
    st_q == ST_IDLE && term && fresh_q && run_src && !FAULT_TRIP;
  endsequence

  sequence s_trip_reset;
    trip_rst_ok && term && run_src;
  endsequence

  a_trip_output_off: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE5
    FAULT_TRIP |-> !OUTPUT_EN ##1 (OUT_FREQ == 16'h0000))
    else $error("output not cut on trip");
  a_pwron_start: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE1
    (s_pwron_cmd and pwron_q) |=> (st_q == ST_RUN) && OUTPUT_EN)
    else $error("power-up run did not start");
  a_pwron_blocked: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE2
    (s_pwron_cmd and !pwron_q) |=> (st_q == ST_HOLD_OFF) && !OUTPUT_EN)
    else $error("run started without power-on run");
  a_pwron_search: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE3
    (s_pwron_cmd and (pwron_q && ssopt_q[SS_PWRON_BIT])) |=> SEARCH_REQ ##1 !SEARCH_REQ)
    else $error("no search pulse on power-up start");
  a_plain_start: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE4
    start_go && !start_search |=> OUT_FREQ == 16'h0000 && !SEARCH_REQ)
    else $error("plain start not from standstill");
  a_reset_restart: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE6
    (s_trip_reset and rstrt_q) |=> st_q == ST_RUN ##0 SEARCH_REQ == $past(ssopt_q[SS_TRIP_BIT]))
    else $error("reset restart did not resume");
  a_no_restart: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE9
    (s_trip_reset and !rstrt_q) |=> st_q == ST_HOLD_OFF [*2] or !run_src)
    else $error("restarted without off and on");
  a_retry_spent: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE16
    st_q == ST_RETRY && st_d == ST_RUN |=> retries_q == $past(retries_q) - 4'h1)
    else $error("auto restart not counted");
  a_retry_empty: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE16
    st_q == ST_TRIP && retries_q == 4'h0 |=> st_q != ST_RETRY)
    else $error("auto restart after count used up");
  a_ramp_step: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE10
    st_q == ST_RUN && $past(st_q) == ST_RUN && $past(den) != 24'h000000 && !$past(start_go)
    |-> (OUT_FREQ - $past(OUT_FREQ) == 16'h0001) || ($past(OUT_FREQ) - OUT_FREQ == 16'h0001)
        || OUT_FREQ == $past(OUT_FREQ))
    else $error("ramp jumped by more than one step");

endmodule : rsr_run_ramp_ctrl

//--- rsr_stage_model.sv
/*
 * Output stage partner: motor speed estimate fed back for speed search.
 * Assumes the drive's clock, enable high while driving, 0.01 Hz units.
 */
`timescale 1ns/1ps
module rsr_stage_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // from the drive
  input  wire logic        out_en,
  input  wire logic [15:0] out_freq,
  // speed estimate
  output logic      [15:0] speed_est
);
  logic [5:0] div_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output off coasts
  // coasting load sheds speed slowly, so a search finds it still turning
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_est <= 16'h0000;
    end else if (out_en) begin
      speed_est <= out_freq;
    end else if (div_q == 6'h00 && speed_est != 16'h0000) begin
      speed_est <= speed_est - 16'h0001;
    end
  end
endmodule : rsr_stage_model

//--- rsr_run_ramp_ctrl_tb.sv
/*
 * Self-checking bench: APB master, terminal run and fault stimulus,
 * integer ramp and retry model. Assumes a shortened 10 ms tick.
 */
`timescale 1ns/1ps
module rsr_run_ramp_ctrl_tb;
  import rsr_pkg::*;
  localparam int TK = 120;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        run, trip, frst, out_en, sreq, irq;
  logic [15:0] sfreq, ofreq;
  int          mismatches, cmp_count, cyc, n;
  logic        sr;
  logic [31:0] rq;
  logic        re;

  rsr_run_ramp_ctrl #(.TICK_CYCLES_P(TK)) dut (
    .SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RUN_CMD(run), .FAULT_TRIP(trip), .FAULT_RESET(frst),
    .SEARCH_FREQ(sfreq), .OUTPUT_EN(out_en), .SEARCH_REQ(sreq),
    .OUT_FREQ(ofreq), .IRQ(irq));

  rsr_stage_model stage (.clk(clk), .rst(rst), .out_en(out_en),
    .out_freq(ofreq), .speed_est(sfreq));

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1, d, q, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(a, 0, 0, q, e);
    chk(nm, q, x);
  endtask : rdc

  function automatic logic [31:0] ctl(int src, pw, rs, rf, ts, ss);
    return 32'(src | pw << 3 | rs << 4 | rf << 5 | ts << 6 | ss << 16);
  endfunction : ctl

  // cycles until the output comes on, noting any search request
  task automatic wait_on(input int lim);
    n = 0;
    sr = 0;
    while (out_en !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
      sr |= (sreq === 1'b1);
    end
  endtask : wait_on

  task automatic stop;
    run <= 0;
    n = 0;
    while (out_en !== 1'b0 && n < 5000) begin @(posedge clk); n++; end
    chk("stop", out_en, 0);
  endtask : stop

  // den = count times unit multiplier; ref 0 scales by target over max
  task automatic ramp(input int ts, input int rf);
    int t, den, x;
    t = 80 + $urandom % 41;
    den = 40 * (ts == 0 ? 1 : ts == 1 ? 10 : 100);
    x = (rf != 0 ? den : t * den / 4000) * TK;
    wr(OFS_TARGET_FREQ, t);
    wr(OFS_CTRL, ctl(1, 0, 0, rf, ts, 0));
    rdc("accel_count", OFS_ACCEL_TIME, 40);
    run <= 1;
    n = 0;
    sr = 0;
    while (ofreq !== t[15:0] && n < 20000) begin
      @(posedge clk);
      n++;
      sr |= (sreq === 1'b1);
    end
    chk("ramp_time", 32'(n > x - 250 && n < x + 250), 1);
    chk("no_search", sr, 0);
    stop();
  endtask : ramp

  task automatic trip_once;
    @(posedge clk);
    trip <= 1;
    #1 chk("trip_off", out_en, 0);
    @(posedge clk);
    trip <= 0;
  endtask : trip_once

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    run = 1; trip = 0; frst = 0;
    void'($urandom(19));
    repeat (20) @(posedge clk);
    rst <= 0;
    rdc("ctrl", OFS_CTRL, 32'h00000041);
    rdc("accel", OFS_ACCEL_TIME, 200);
    rdc("decel", OFS_DECEL_TIME, 300);
    rdc("maxf", OFS_MAX_FREQ, 6000);
    rdc("rcount", OFS_RETRY_COUNT, 0);
    rdc("rdelay", OFS_RETRY_DELAY, 10);
    apb(8'h3c, 0, 0, rq, re);
    chk("unmapped", rq, 0);
    chk("slverr", re, 1);
    // run held through power-up is ignored until cycled
    repeat (40) @(posedge clk);
    chk("pwr_hold", out_en, 0);
    run <= 0;
    @(posedge clk);
    run <= 1;
    wait_on(40);
    chk("cycled_run", out_en, 1);
    stop();
    wr(OFS_MAX_FREQ, 4000);
    wr(OFS_ACCEL_TIME, 40);
    wr(OFS_DECEL_TIME, 1);
    wr(OFS_RETRY_DELAY, 1);
    wr(OFS_RETRY_COUNT, 2);
    wr(OFS_INT_MASK, 1);
    for (int ts = 0; ts < 3; ts++) ramp(ts, 0);
    ramp(0, 1);
    // two automatic retries with search, then the count is spent
    wr(OFS_CTRL, ctl(1, 0, 1, 0, 0, 8'h04));
    wr(OFS_TARGET_FREQ, 100);
    run <= 1;
    wait_on(100);
    repeat (2) begin
      trip_once();
      wait_on(3000);
      chk("retry_delay", 32'(n > 1200 - 250 && n < 1200 + 250), 1);
      chk("trip_search", sr, 1);
    end
    trip_once();
    repeat (2000) @(posedge clk);
    chk("spent", out_en, 0);
    rdc("status", OFS_STATUS, 32'h00000800);
    chk("irq_on", irq, 1);
    wr(OFS_INT_STATUS, 32'h0000000f);
    @(posedge clk);
    chk("irq_clr", irq, 0);
    @(posedge clk);
    frst <= 1;
    @(posedge clk);
    frst <= 0;
    wait_on(5);
    chk("rst_restart", out_en, 1);
    // without reset-restart: reset, then off and on
    wr(OFS_CTRL, ctl(1, 0, 0, 0, 0, 0));
    trip_once();
    frst <= 1;
    @(posedge clk);
    frst <= 0;
    repeat (40) @(posedge clk);
    chk("no_restart", out_en, 0);
    run <= 0;
    @(posedge clk);
    run <= 1;
    wait_on(40);
    chk("cycle_start", out_en, 1);
    // power-up with run already on and power-on run chosen
    rst <= 1;
    repeat (20) @(posedge clk);
    rst <= 0;
    wr(OFS_CTRL, ctl(0, 1, 0, 0, 1, 8'h10));
    wr(OFS_CTRL, ctl(1, 1, 0, 0, 1, 8'h10));
    wait_on(40);
    chk("pwr_run", out_en, 1);
    chk("pwr_search", sr, 1);
    results();
  end
endmodule : rsr_run_ramp_ctrl_tb
